// *** shared/dmpc_pkg.sv ***
// Package of constants and types for the DRAM memory pin control block
//
// Summary of operation
// RQ1: Drive 11-bit multiplexed DRAM address bus directly.
// RQ2: Eight column strobes per bank and byte lane.
// RQ3: Four row strobes, addressed bank asserted.
// RQ4: Write strobe low during on-board memory writes.
// RQ5: Direction low on reads, high on writes; ROM writes keep it low.
// RQ6: Two active-low parity error inputs, low/high byte.
// RQ7: ROM output enable asserted during ROM reads.
// RQ8: ROM enable pin is power-up strap; low means 8-bit.
// RQ9: Non-maskable interrupt on parity error or channel check.
// RQ10: Sample strap in reset, drive pin after release; the strap is latched on the third clock after reset release.
package dmpc_pkg;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int DMPC_ADDR_W = 11;
    localparam int DMPC_BANKS = 4;
    localparam int DMPC_LANES = 2;
    localparam logic [10:0] DMPC_ADDR_RST = 11'h000;
    localparam logic [3:0] DMPC_RAS_IDLE = 4'hf;
    localparam logic [7:0] DMPC_CAS_IDLE = 8'hff;
    localparam logic DMPC_WIDTH_RST = 1'h0;

    // Access sequence states, Gray coded along idle-row-col-done
    typedef enum logic [1:0] {
        DMPC_IDLE = 2'b00,
        DMPC_ROW = 2'b01,
        DMPC_COL = 2'b11,
        DMPC_DONE = 2'b10
    } dmpc_state_t;
endpackage

// *** verilog/dmpc_pin_ctrl.sv ***
// Memory-side pin control: DRAM strobes, address mux, ROM enable, parity NMI
`timescale 1ns/1ps
module dmpc_pin_ctrl
    import dmpc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic req_rom_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_bank_i,
    input wire logic [1:0] req_lane_en_i,
    input wire logic [10:0] req_row_i,
    input wire logic [10:0] req_col_i,
    input wire logic parity_err_low_byte_n_i,
    input wire logic parity_err_high_byte_n_i,
    input wire logic io_channel_check_i,
    input wire logic rom_output_enable_n_i,
    output logic rom_output_enable_n_o,
    output logic rom_output_enable_n_oe_o,
    output logic rom_8bit_o,
    output logic busy_o,
    output logic [10:0] dram_addr_bus_o,
    output logic [3:0] row_strobe_bank_n_o,
    output logic [7:0] col_strobe_n_o,
    output logic dram_write_strobe_n_o,
    output logic mem_data_direction_o,
    output logic cpu_nonmaskable_irq_o
);
    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        dmpc_state_t st;
        logic rom;
        logic wr;
        logic [1:0] bank;
        logic [1:0] lanes;
        logic [10:0] col;
        logic [10:0] addr;
        logic [3:0] ras_n;
        logic [7:0] cas_n;
        logic we_n;
        logic dir;
        logic romoe_n;
        logic romoe_oe;
        logic rom8;
        logic strap_done;
        logic [1:0] parity_s1;
        logic [1:0] parity_s2;
        logic [1:0] chk_s;
        logic [1:0] strap_s;
        // Marks which synchroniser stages already hold a real pin sample
        logic [1:0] strap_v;
        logic nmi;
        logic busy;
    } dmpc_reg_t;

    dmpc_reg_t r;
    dmpc_reg_t next_r;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        // Pin inputs pass two flops before use
        next_r.parity_s1 = {parity_err_high_byte_n_i, parity_err_low_byte_n_i}; // RQ6
        next_r.parity_s2 = r.parity_s1;
        next_r.chk_s = {r.chk_s[0], io_channel_check_i};
        next_r.strap_s = {r.strap_s[0], rom_output_enable_n_i};
        next_r.strap_v = {r.strap_v[0], 1'b1};
        // NMI follows either parity byte or channel check
        next_r.nmi = (~r.parity_s2[0]) | (~r.parity_s2[1]) | r.chk_s[1]; // RQ9
        // Latch strap once, only after a real pin sample reached stage two;
        // the reset value of the synchroniser would otherwise be latched
        if (!r.strap_done && r.strap_v[1]) begin
            next_r.rom8 = ~r.strap_s[1]; // RQ8
            next_r.strap_done = 1'b1; // RQ10
            next_r.romoe_oe = 1'b1; // RQ10
        end
        unique case (r.st)
            DMPC_IDLE: begin
                if (req_i && r.strap_done) begin
                    next_r.rom = req_rom_i;
                    next_r.wr = req_write_i;
                    next_r.bank = req_bank_i;
                    next_r.lanes = req_lane_en_i;
                    next_r.col = req_col_i;
                    next_r.st = DMPC_ROW;
                    if (req_rom_i) begin
                        next_r.romoe_n = req_write_i; // RQ7
                        next_r.dir = 1'b0;
                    end else begin
                        next_r.addr = req_row_i; // RQ1
                        next_r.ras_n = ~(4'h1 << req_bank_i); // RQ3
                        next_r.dir = req_write_i; // RQ5
                    end
                end
            end
            DMPC_ROW: begin
                // Row held one cycle before column phase for address setup
                next_r.st = DMPC_COL;
                if (!r.rom) begin
                    next_r.addr = r.col; // RQ1
                    next_r.we_n = ~r.wr; // RQ4
                end
            end
            DMPC_COL: begin
                next_r.st = DMPC_DONE;
                if (!r.rom) begin
                    for (int b = 0; b < DMPC_BANKS; b++) begin
                        for (int l = 0; l < DMPC_LANES; l++) begin
                            next_r.cas_n[b*DMPC_LANES+l] =
                                ~((r.bank == b[1:0]) && r.lanes[l]); // RQ2
                        end
                    end
                end
            end
            DMPC_DONE: begin
                next_r.st = DMPC_IDLE;
                next_r.ras_n = DMPC_RAS_IDLE;
                next_r.cas_n = DMPC_CAS_IDLE;
                next_r.we_n = 1'b1;
                next_r.romoe_n = 1'b1;
                next_r.dir = 1'b0;
            end
        endcase
        // Busy is registered so the pin-side outputs all leave flops
        next_r.busy = (next_r.st != DMPC_IDLE) | ~next_r.strap_done;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{st: DMPC_IDLE, rom: 1'b0, wr: 1'b0, bank: 2'h0, lanes: 2'h0,
                   col: DMPC_ADDR_RST, addr: DMPC_ADDR_RST, ras_n: DMPC_RAS_IDLE,
                   cas_n: DMPC_CAS_IDLE, we_n: 1'b1, dir: 1'b0, romoe_n: 1'b1,
                   romoe_oe: 1'b0, rom8: DMPC_WIDTH_RST, strap_done: 1'b0,
                   parity_s1: 2'h3, parity_s2: 2'h3, chk_s: 2'h0, strap_s: 2'h3,
                   strap_v: 2'h0, nmi: 1'b0, busy: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    // Outputs all straight from flops
    assign rom_output_enable_n_o = r.romoe_n;
    assign rom_output_enable_n_oe_o = r.romoe_oe;
    assign rom_8bit_o = r.rom8;
    assign busy_o = r.busy;
    assign dram_addr_bus_o = r.addr;
    assign row_strobe_bank_n_o = r.ras_n;
    assign col_strobe_n_o = r.cas_n;
    assign dram_write_strobe_n_o = r.we_n;
    assign mem_data_direction_o = r.dir;
    assign cpu_nonmaskable_irq_o = r.nmi;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_row_phase;
        r.st == DMPC_ROW && !r.rom;
    endsequence

    // Column strobes: quiet in the column-address cycle, one pulse, then quiet
    sequence s_cas_pulse;
        (col_strobe_n_o == DMPC_CAS_IDLE)
        ##1 (col_strobe_n_o != DMPC_CAS_IDLE || r.lanes == 2'h0)
        ##1 (col_strobe_n_o == DMPC_CAS_IDLE);
    endsequence

    // Row strobe stands for the three busy cycles, then is released
    sequence s_ras_span;
        ($countones(~row_strobe_bank_n_o) == 1) [*3]
        ##1 (row_strobe_bank_n_o == DMPC_RAS_IDLE);
    endsequence

    a_col_bank_match: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ2
        (r.cas_n != DMPC_CAS_IDLE) |-> (r.ras_n == ~(4'h1 << r.bank)))
        else $error("column strobe outside addressed bank");
    a_row_onehot: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ3
        s_row_phase |-> $countones(~r.ras_n) == 1)
        else $error("row strobe not one-hot");
    a_addr_mux: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ1
        s_row_phase |=> dram_addr_bus_o == $past(r.col))
        else $error("column address not driven");
    a_write_dir: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ4
        !dram_write_strobe_n_o |-> mem_data_direction_o)
        else $error("write strobe with read direction");
    a_read_dir: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ5
        (r.st == DMPC_COL && !r.wr && !r.rom) |-> !mem_data_direction_o)
        else $error("read with write direction");
    a_rom_oe: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ7
        !rom_output_enable_n_o |-> (r.rom && !r.wr && rom_output_enable_n_oe_o))
        else $error("ROM enable outside ROM read");
    a_nmi_parity: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ9
        (!parity_err_low_byte_n_i [*4]) |-> cpu_nonmaskable_irq_o)
        else $error("parity error gave no NMI");
    a_strap_drive: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ10
        rom_output_enable_n_oe_o |-> r.strap_done)
        else $error("ROM pin driven before strap taken");
    a_strap_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ8
        r.strap_done && $past(r.strap_done) |-> $stable(rom_8bit_o))
        else $error("ROM width changed after capture");
    a_cas_one_pulse: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ2
        s_row_phase |=> s_cas_pulse)
        else $error("column strobe not a single pulse");
    a_ras_span: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ3
        s_row_phase |-> s_ras_span)
        else $error("row strobe span wrong");
    a_idle_release: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ3
        (r.st == DMPC_IDLE) |-> (row_strobe_bank_n_o == DMPC_RAS_IDLE
            && col_strobe_n_o == DMPC_CAS_IDLE && dram_write_strobe_n_o))
        else $error("strobes active while idle");
    a_we_dram_only: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ4
        !dram_write_strobe_n_o |-> (r.wr && !r.rom))
        else $error("write strobe outside DRAM write");
    a_write_dir_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ5
        (r.st == DMPC_COL && r.wr && !r.rom) |-> mem_data_direction_o)
        else $error("write without write direction");
    a_rom_no_ras: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ7
        (r.rom && r.st != DMPC_IDLE) |-> (row_strobe_bank_n_o == DMPC_RAS_IDLE))
        else $error("row strobe during ROM access");
    a_nmi_high_byte: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ6
        (!parity_err_high_byte_n_i [*4]) |-> cpu_nonmaskable_irq_o)
        else $error("high byte parity error gave no NMI");
    a_nmi_check: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ9
        (io_channel_check_i [*4]) |-> cpu_nonmaskable_irq_o)
        else $error("channel check gave no NMI");
    a_nmi_quiet: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ9
        ((parity_err_low_byte_n_i && parity_err_high_byte_n_i
            && !io_channel_check_i) [*4]) |-> !cpu_nonmaskable_irq_o)
        else $error("NMI without a fault source");
    a_busy_access: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // RQ10
        (s_row_phase or !r.strap_done) |-> busy_o)
        else $error("busy low during access or before strap");
endmodule

// *** sim/dmpc_mem_model.sv ***
// Behavioural board model around the ROM enable pin and its width strap
`timescale 1ns/1ps
module dmpc_mem_model (
    input wire logic strap_low_i,
    input wire logic pin_drv_i,
    input wire logic pin_oe_i,
    output logic pin_o
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Board pull sets the level whenever the device lets go of the pin
    assign pin_o = pin_oe_i ? pin_drv_i : !strap_low_i;
endmodule

// *** sim/dram_memory_pin_control_bench.sv ***
// Self-checking bench for the DRAM memory pin control block
`timescale 1ns/1ps
module dram_memory_pin_control_bench;
    import dmpc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, checks and verdict
    // ------------------------------------------------------------
    logic clk = 0, rst_n = 0, req = 0, rom = 0, wr = 0, pl_n = 1, ph_n = 1, chk = 0, s_low = 0;
    logic [1:0] bank = 0, lanes = 0;
    logic [10:0] row = 0, col = 0, addr;
    logic pin, drv, oe, rom8, busy, we_n, dir, nmi;
    logic [3:0] ras_n;
    logic [7:0] cas_n;
    int mismatches = 0, comparisons = 0;
    always #25 clk = ~clk;
    dmpc_mem_model dmpc_mem_model_inst (.strap_low_i(s_low), .pin_drv_i(drv), .pin_oe_i(oe),
        .pin_o(pin));
    dmpc_pin_ctrl dmpc_pin_ctrl_inst (.core_clk_i(clk), .resetn_i(rst_n), .req_i(req),
        .req_rom_i(rom), .req_write_i(wr), .req_bank_i(bank), .req_lane_en_i(lanes),
        .req_row_i(row), .req_col_i(col), .parity_err_low_byte_n_i(pl_n),
        .parity_err_high_byte_n_i(ph_n), .io_channel_check_i(chk),
        .rom_output_enable_n_i(pin), .rom_output_enable_n_o(drv),
        .rom_output_enable_n_oe_o(oe), .rom_8bit_o(rom8), .busy_o(busy),
        .dram_addr_bus_o(addr), .row_strobe_bank_n_o(ras_n), .col_strobe_n_o(cas_n),
        .dram_write_strobe_n_o(we_n), .mem_data_direction_o(dir),
        .cpu_nonmaskable_irq_o(nmi));
    task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Reset with a chosen strap; the pull stays on while the pin is released
    task automatic do_reset(input logic low);
        s_low = low;
        rst_n = 0;
        repeat (10) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        cmp("rom8", low, rom8);
        cmp("pin_oe", 1, oe);
        cmp("busy", 0, busy);
    endtask
    // One access, checked stage by stage after each edge
    task automatic access(input logic r, w, input logic [1:0] b, l, input logic [10:0] ra, ca);
        @(negedge clk);
        {rom, wr, bank, lanes, row, col, req} = {r, w, b, l, ra, ca, 1'b1};
        @(negedge clk);
        req = 0;
        cmp("ras_n", r ? 4'hf : 4'(~(4'h1 << b)), ras_n);
        cmp("romoe_n", !(r && !w), drv);
        cmp("busy", 1, busy);
        if (!r) cmp("addr_row", ra, addr);
        if (!r) cmp("dir", w, dir);
        @(negedge clk);
        if (!r) cmp("addr_col", ca, addr);
        cmp("we_n", !(w && !r), we_n);
        @(negedge clk);
        cmp("cas_n", r ? 8'hff : 8'(~({6'h0, l} << (2 * b))), cas_n);
        @(negedge clk);
        cmp("cas_idle", 8'hff, cas_n);
        cmp("ras_idle", 4'hf, ras_n);
        cmp("romoe_idle", 1, drv);
        cmp("busy_end", 0, busy);
    endtask
    // Each fault source alone raises the interrupt, and it drops on release
    task automatic nmi_src(input int k);
        @(negedge clk);
        {pl_n, ph_n, chk} = {k != 0, k != 1, k == 2};
        repeat (4) @(negedge clk);
        cmp("nmi_set", 1, nmi);
        {pl_n, ph_n, chk} = 3'b110;
        repeat (4) @(negedge clk);
        cmp("nmi_clr", 0, nmi);
    endtask
    initial begin
        do_reset(0);
        do_reset(1);
        for (int b = 0; b < 4; b++) access(0, 0, 2'(b), 2'(b % 3 + 1), 11'h7a5 - 11'(b), 11'h05a);
        access(0, 1, 2, 3, 11'h400, 11'h3ff);
        access(1, 0, 1, 3, 11'h001, 11'h002);
        access(1, 1, 0, 3, 11'h001, 11'h002);
        for (int k = 0; k < 3; k++) nmi_src(k);
        print_verdict();
    end
    // Watchdog far beyond the 88 cycles the run needs
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule
